// ### verilog/fsp_pkg.sv
/*
 * Shared constants and carrier types for the flash security and
 * protection register block: register offsets, field positions,
 * reset values and the request structs used on the user-side ports.
 * Assumes a 32-bit AXI4-Lite register bus and a 16-bit flash address.
 */
package fsp_pkg;

	////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_OPTION = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_PROTECT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int OPT_KEY_UNLOCK_ENABLE_BIT = 7;
	localparam int OPT_NORED_BIT = 6;
	localparam int OPT_SEC_LSB = 0;
	localparam int CFG_KEY_WRITE_ACCESS_BIT = 5;
	localparam int CFG_RW_LSB = 5;
	localparam int PROT_DIS_BIT = 0;
	localparam int PROT_FPS_LSB = 1;
	localparam int STAT_VIOL_BIT = 0;
	localparam int STAT_SECURE_BIT = 1;

	////////////////////////////////////////////////////////////////////
	// Masks and values
	localparam logic [7:0] OPT_READ_MASK = 8'hC3;
	localparam logic [7:0] CFG_RW_MASK = 8'hE0;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;

	////////////////////////////////////////////////////////////////////
	// Reset values (shadows are reloaded from nonvolatile bytes after reset)
	localparam logic [7:0] OPTION_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] PROTECT_RST = 8'h00;

	////////////////////////////////////////////////////////////////////
	// Key window and protection granularity
	localparam logic [15:0] KEY_BASE = 16'hFFB0;
	localparam logic [15:0] KEY_LAST = 16'hFFB7;
	localparam int KEY_BYTES = 8;
	localparam int BLOCK_SHIFT = 9;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Byte write into flash address space from the CPU or debug port
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic from_debug;
	} fsp_flash_wr_t;

	// Erase or program command presented for protection checking
	typedef struct packed {
		logic [15:0] addr;
		logic is_erase;
	} fsp_cmd_t;

	// Memory-content access request and its source
	typedef struct packed {
		logic [15:0] addr;
		logic from_unsecured;
	} fsp_mem_req_t;

endpackage

// ### verilog/fsp_regs.sv
/*
 * Flash option, configuration and protection register logic with
 * backdoor key unlock, security gating and high-end block protection.
 * Assumes one bus clock, an AXI4-Lite master for the registers, and that
 * the nonvolatile bytes and key are stable at inputs when reset releases.
 */
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
//
// Overview of operation
// - Every reset reloads the option shadow from the option nonvolatile byte.
// - Option shadow bits 5..2 are unused and read zero.
// - Option shadow is always readable; writes do nothing.
// - Key unlock enable at 0 forbids unlocking through the key compare.
// - Only firmware writes load comparison bytes; debug writes never do.
// - Matching 8 ascending key bytes with unlock enabled unsecures until reset.
// - Option bit 6 at 1 disables vector redirection, at 0 allows it.
// - Security code 10 means unsecured; 00, 01, 11 mean secured.
// - While secured, memory access from unsecured sources is blocked.
// - Security code becomes 10 after key match or all-blank check.
// - Configuration bits 7..5 are read and write at any time.
// - Configuration bits 4..0 read zero and ignore writes.
// - Key access bit 0: key-range writes start a flash command.
// - Key access bit 1: key-range writes are key bytes; flash reads invalid.
// - Every reset reloads the protection shadow from its nonvolatile byte.
// - Firmware writes to protection shadow ignored; debug writes it; always readable.
// - Boundary field sets end of unprotected flash; higher blocks reject erase/program.
// - Protection disable bit 1 protects nothing; 0 protects the blocks above the boundary block.
// - Commands on protected locations are dropped and set a write-one-clear flag.
`timescale 1ns/100ps
module fsp_regs
(
	input wire logic ref_clk,
	input wire logic nrst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Nonvolatile contents
	input wire logic [7:0] option_nv_byte,
	input wire logic [7:0] protect_nv_byte,
	input wire logic [63:0] nv_unlock_key,
	// Debug rewrite of the protection shadow
	input wire logic dbg_protect_wr,
	input wire logic [7:0] dbg_protect_data,
	// Byte writes into flash space
	input wire logic flash_wr_valid,
	input wire fsp_pkg::fsp_flash_wr_t flash_wr,
	output logic cmd_start,
	output fsp_pkg::fsp_flash_wr_t cmd_start_wr,
	// Erase/program commands for protection check
	input wire logic cmd_valid,
	input wire fsp_pkg::fsp_cmd_t cmd,
	output logic cmd_go,
	output fsp_pkg::fsp_cmd_t cmd_go_info,
	// Blank check of whole array passed
	input wire logic blank_ok,
	// Memory access gating
	input wire logic mem_req_valid,
	input wire fsp_pkg::fsp_mem_req_t mem_req,
	output logic mem_grant,
	output logic mem_deny,
	// Status outputs
	output logic secure,
	output logic vector_redirect_disable,
	output logic flash_read_invalid
);

	////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [0:0] {FSP_LOAD = 1'b0, FSP_RUN = 1'b1} fsp_phase_t;

	fsp_phase_t phase_r;
	logic [7:0] option_shadow_r;
	logic [7:0] flash_config_r;
	logic [7:0] protect_shadow_r;
	logic protect_violation_flag_r;
	logic [2:0] key_idx_r;
	logic key_bad_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	logic key_unlock_enable;
	logic [1:0] security_code;
	logic protect_disable;
	logic [6:0] protect_boundary_select;
	logic key_write_access;
	logic in_key_range;
	logic key_byte_wr;
	logic key_byte_ok;
	logic key_last;
	logic key_match;
	logic cmd_protected;
	logic wr_fire;
	logic viol_clear;
	logic [7:0] key_exp;

	assign key_unlock_enable = option_shadow_r[fsp_pkg::OPT_KEY_UNLOCK_ENABLE_BIT];
	assign security_code = option_shadow_r[fsp_pkg::OPT_SEC_LSB +: 2];
	assign protect_disable = protect_shadow_r[fsp_pkg::PROT_DIS_BIT];
	assign protect_boundary_select = protect_shadow_r[fsp_pkg::PROT_FPS_LSB +: 7];
	assign key_write_access = flash_config_r[fsp_pkg::CFG_KEY_WRITE_ACCESS_BIT];

	////////////////////////////////////////////////////////////////////
	// Nonvolatile load phase: one cycle after reset release
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			phase_r <= FSP_LOAD;
		else
			phase_r <= FSP_RUN;
	end

	////////////////////////////////////////////////////////////////////
	// Key entry: firmware byte writes in ascending order
	assign in_key_range = flash_wr.addr >= fsp_pkg::KEY_BASE
		&& flash_wr.addr <= fsp_pkg::KEY_LAST;
	// Debug-sourced writes are never key bytes
	assign key_byte_wr = phase_r == FSP_RUN && flash_wr_valid && in_key_range
		&& key_write_access && !flash_wr.from_debug;
	assign key_exp = nv_unlock_key[63 - 8 * key_idx_r -: 8];
	assign key_byte_ok = flash_wr.addr[2:0] == key_idx_r && flash_wr.data == key_exp;
	assign key_last = key_idx_r == 3'(fsp_pkg::KEY_BYTES - 1);
	assign key_match = key_byte_wr && key_last && !key_bad_r && key_byte_ok
		&& key_unlock_enable;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			key_idx_r <= 3'h0;
			key_bad_r <= 1'b0;
		end
		else if (key_byte_wr)
		begin
			// Wraps after eight bytes; a mismatch only poisons this entry
			key_idx_r <= key_idx_r + 3'h1;
			key_bad_r <= key_last ? 1'b0 : (key_bad_r || !key_byte_ok);
		end
		else if (!key_write_access)
		begin
			key_idx_r <= 3'h0;
			key_bad_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Option shadow: loaded at reset, only the security code can change
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			option_shadow_r <= fsp_pkg::OPTION_RST;
		else if (phase_r == FSP_LOAD)
			option_shadow_r <= option_nv_byte & fsp_pkg::OPT_READ_MASK;
		else if (key_match || blank_ok)
			option_shadow_r[fsp_pkg::OPT_SEC_LSB +: 2] <= fsp_pkg::SEC_UNSECURED;
	end

	////////////////////////////////////////////////////////////////////
	// Protection shadow: reset load, then debug writes only
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			protect_shadow_r <= fsp_pkg::PROTECT_RST;
		else if (phase_r == FSP_LOAD)
			protect_shadow_r <= protect_nv_byte;
		else if (dbg_protect_wr)
			protect_shadow_r <= dbg_protect_data;
	end

	////////////////////////////////////////////////////////////////////
	// Command protection check, 512-byte blocks up to the top
	assign cmd_protected = !protect_disable
		&& cmd.addr[15:fsp_pkg::BLOCK_SHIFT] > protect_boundary_select;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cmd_go <= 1'b0;
			cmd_go_info <= '0;
		end
		else
		begin
			cmd_go <= cmd_valid && !cmd_protected && phase_r == FSP_RUN;
			cmd_go_info <= cmd;
		end
	end

	// Set wins over a simultaneous software clear
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			protect_violation_flag_r <= 1'b0;
		else if (cmd_valid && cmd_protected && phase_r == FSP_RUN)
			protect_violation_flag_r <= 1'b1;
		else if (viol_clear)
			protect_violation_flag_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Key-range writes start a command when key access is off
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cmd_start <= 1'b0;
			cmd_start_wr <= '0;
		end
		else
		begin
			cmd_start <= phase_r == FSP_RUN && flash_wr_valid && !key_write_access;
			cmd_start_wr <= flash_wr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Security gating and status outputs
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_grant <= 1'b0;
			mem_deny <= 1'b0;
			secure <= 1'b1;
			vector_redirect_disable <= 1'b0;
			flash_read_invalid <= 1'b0;
		end
		else
		begin
			mem_grant <= mem_req_valid && !(secure && mem_req.from_unsecured);
			mem_deny <= mem_req_valid && secure && mem_req.from_unsecured;
			secure <= phase_r == FSP_LOAD || security_code != fsp_pkg::SEC_UNSECURED;
			vector_redirect_disable <= option_shadow_r[fsp_pkg::OPT_NORED_BIT];
			flash_read_invalid <= key_write_access;
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order
	assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign viol_clear = wr_fire && aw_addr_r == fsp_pkg::OFS_STATUS && w_strb_r[0]
		&& w_data_r[fsp_pkg::STAT_VIOL_BIT];

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_hold_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fsp_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= aw_addr_r[7:2] > fsp_pkg::OFS_STATUS[7:2] || aw_addr_r[1:0] != 2'h0
				? fsp_pkg::RESP_SLVERR : fsp_pkg::RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Only bits 7..5 of the configuration register take writes
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			flash_config_r <= fsp_pkg::CONFIG_RST;
		else if (wr_fire && aw_addr_r == fsp_pkg::OFS_CONFIG && w_strb_r[0])
			flash_config_r <= w_data_r[7:0] & fsp_pkg::CFG_RW_MASK;
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path, one read at a time
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= fsp_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= fsp_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					fsp_pkg::OFS_OPTION:
						s_axi_rdata <= {24'h00_0000, option_shadow_r};
					fsp_pkg::OFS_CONFIG:
						s_axi_rdata <= {24'h00_0000, flash_config_r};
					fsp_pkg::OFS_PROTECT:
						s_axi_rdata <= {24'h00_0000, protect_shadow_r};
					fsp_pkg::OFS_STATUS:
						s_axi_rdata <= {30'h0000_0000, secure, protect_violation_flag_r};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= fsp_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	a_opt_unused_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		option_shadow_r[5:2] == 4'h0)
		else $error("option shadow unused bits not zero");

	a_opt_bus_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase_r == FSP_RUN && !key_match && !blank_ok |=> $stable(option_shadow_r))
		else $error("option shadow changed without cause");

	a_opt_reload: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase_r == FSP_LOAD |=> option_shadow_r == ($past(option_nv_byte) & 8'hC3))
		else $error("option shadow not loaded from nonvolatile byte");

	a_key_needs_en: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase_r == FSP_RUN && !key_unlock_enable && !blank_ok |=> $stable(security_code))
		else $error("security changed with key unlock disabled");

	a_dbg_no_key: assert property (@(posedge ref_clk) disable iff (!nrst)
		flash_wr_valid && flash_wr.from_debug |=> $stable(key_idx_r))
		else $error("debug write advanced key entry");

	a_unlock_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
		key_match || (blank_ok && phase_r == FSP_RUN) |=> security_code == 2'h2 ##1 !secure)
		else $error("unlock did not clear security");

	a_secure_decode: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase_r == FSP_RUN ##1 security_code != 2'h2 |=> secure)
		else $error("secured code not reported secure");

	a_mem_blocked: assert property (@(posedge ref_clk) disable iff (!nrst)
		mem_req_valid && secure && mem_req.from_unsecured |=> mem_deny && !mem_grant)
		else $error("unsecured access not blocked");

	a_cfg_low_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		flash_config_r[4:0] == 5'h00)
		else $error("configuration low bits not zero");

	a_prot_fw_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase_r == FSP_RUN && !dbg_protect_wr |=> $stable(protect_shadow_r))
		else $error("protection shadow changed without debug write");

	a_viol_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
		cmd_valid && cmd_protected && phase_r == FSP_RUN
		|=> !cmd_go && protect_violation_flag_r)
		else $error("protected command not dropped");

	a_keyrange_cmd: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase_r == FSP_RUN && flash_wr_valid && !key_write_access |=> cmd_start)
		else $error("key range write did not start command");

	c_key_unlock: cover property (@(posedge ref_clk) disable iff (!nrst) key_match);
	c_key_reject: cover property (@(posedge ref_clk) disable iff (!nrst)
		key_byte_wr && key_last && key_bad_r);
	c_violation: cover property (@(posedge ref_clk) disable iff (!nrst)
		cmd_valid && cmd_protected);
	c_blank_unlock: cover property (@(posedge ref_clk) disable iff (!nrst)
		blank_ok && secure);

endmodule

// ### testbench/fsp_regs_test.sv
/*
 * Self-checking bench for the flash security and protection register block.
 * Assumes fsp_pkg and fsp_regs are compiled first; the bench drives every port.
 */
`timescale 1ns/100ps
module fsp_regs_test;
	logic ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, option_nv_byte, protect_nv_byte, dbg_data, o, b;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [63:0] key;
	logic [6:0] bs;
	logic dbg_wr, fwr_valid, cmd_start, cmd_valid, cmd_go, blank_ok, mreq_valid;
	logic mem_grant, mem_deny, secure, vector_redirect_disable, read_invalid, st, dn;
	fsp_pkg::fsp_flash_wr_t fwr, start_wr;
	fsp_pkg::fsp_cmd_t cmdv, go_info;
	fsp_pkg::fsp_mem_req_t mreq;
	int miscompares, num_checks, seed;

	fsp_regs uut
	(
		.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.option_nv_byte(option_nv_byte), .protect_nv_byte(protect_nv_byte),
		.nv_unlock_key(key), .dbg_protect_wr(dbg_wr), .dbg_protect_data(dbg_data),
		.flash_wr_valid(fwr_valid), .flash_wr(fwr), .cmd_start(cmd_start),
		.cmd_start_wr(start_wr), .cmd_valid(cmd_valid), .cmd(cmdv), .cmd_go(cmd_go),
		.cmd_go_info(go_info), .blank_ok(blank_ok), .mem_req_valid(mreq_valid),
		.mem_req(mreq), .mem_grant(mem_grant), .mem_deny(mem_deny), .secure(secure),
		.vector_redirect_disable(vector_redirect_disable), .flash_read_invalid(read_invalid)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_reset(input logic [7:0] op, input logic [7:0] pr);
		nrst <= 1'b0;
		option_nv_byte <= op;
		protect_nv_byte <= pr;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	// Address and data channels may be taken on different edges
	// Waits without limit for each answer; only the watchdog ends a hung transfer
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge ref_clk);
			if (awready === 1'b1)
				ad = 1'b1;
			if (wready === 1'b1)
				wd = 1'b1;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// One idle edge lets registered side effects settle before the caller looks
		@(posedge ref_clk);
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
		end
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
		begin
			@(posedge ref_clk);
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Pulse requests: the answer stands only in the cycle after the request
	task automatic flash_op(input logic [15:0] a, input logic [7:0] d, input logic dbg,
		output logic s);
		fwr <= '{addr: a, data: d, from_debug: dbg};
		fwr_valid <= 1'b1;
		@(posedge ref_clk);
		fwr_valid <= 1'b0;
		@(posedge ref_clk);
		s = cmd_start;
	endtask

	task automatic cmd_op(input logic [15:0] a, output logic g);
		cmdv <= '{addr: a, is_erase: 1'($random(seed))};
		cmd_valid <= 1'b1;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		@(posedge ref_clk);
		g = cmd_go;
	endtask

	task automatic mem_op(input logic u, output logic g, output logic d);
		mreq <= '{addr: 16'($random(seed)), from_unsecured: u};
		mreq_valid <= 1'b1;
		@(posedge ref_clk);
		mreq_valid <= 1'b0;
		@(posedge ref_clk);
		g = mem_grant;
		d = mem_deny;
	endtask

	task automatic key_entry(input logic [63:0] k, input logic dbg);
		logic s;
		for (int i = 0; i < 8; i++)
		begin
			flash_op(fsp_pkg::KEY_BASE + 16'(i), k[63 - 8 * i -: 8], dbg, s);
			check("cmd_start", 32'h0, 32'(s));
		end
		repeat (3) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		print_verdict();
	end

	initial
	begin
		seed = 32'h754D1B4D;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
		{dbg_wr, fwr_valid, cmd_valid, blank_ok, mreq_valid} <= 5'h0;
		{awaddr, araddr, wdata, wstrb, dbg_data} <= '0;
		fwr <= '0;
		cmdv <= '0;
		mreq <= '0;
		key = {$random(seed), $random(seed)};
		for (int c = 0; c < 4; c++)
		begin
			o = 8'($random(seed));
			o[1:0] = 2'(c);
			b = 8'($random(seed));
			do_reset(o, b);
			axi_read(fsp_pkg::OFS_OPTION, rd, rs);
			check("option", {24'h0, o & 8'hC3}, rd);
			check("secure", 32'(c != 2), 32'(secure));
			check("redirect", 32'(o[6]), 32'(vector_redirect_disable));
			axi_read(fsp_pkg::OFS_PROTECT, rd, rs);
			check("protect", {24'h0, b}, rd);
			axi_write(fsp_pkg::OFS_OPTION, {24'h0, ~o}, rs);
			axi_write(fsp_pkg::OFS_PROTECT, {24'h0, ~b}, rs);
			axi_read(fsp_pkg::OFS_OPTION, rd, rs);
			check("option", {24'h0, o & 8'hC3}, rd);
			axi_read(fsp_pkg::OFS_PROTECT, rd, rs);
			check("protect", {24'h0, b}, rd);
			wdata <= 32'($random(seed));
			@(posedge ref_clk);
			o = wdata[7:0];
			axi_write(fsp_pkg::OFS_CONFIG, wdata, rs);
			axi_read(fsp_pkg::OFS_CONFIG, rd, rs);
			check("config", {24'h0, o & 8'hE0}, rd);
		end
		// Debug port may rewrite the protection shadow
		dbg_data <= ~b;
		dbg_wr <= 1'b1;
		@(posedge ref_clk);
		dbg_wr <= 1'b0;
		@(posedge ref_clk);
		axi_read(fsp_pkg::OFS_PROTECT, rd, rs);
		check("protect", {24'h0, ~b}, rd);
		axi_read(8'h10, rd, rs);
		check("rresp", 32'(fsp_pkg::RESP_SLVERR), 32'(rs));
		axi_write(8'h06, 32'hFF, rs);
		check("bresp", 32'(fsp_pkg::RESP_SLVERR), 32'(rs));
		// Backdoor key: secured part with key unlock enabled
		do_reset(8'h80, 8'h01);
		mem_op(1'b1, st, dn);
		check("mem_deny", 32'h1, {30'h0, st, dn});
		mem_op(1'b0, st, dn);
		check("mem_grant", 32'h2, {30'h0, st, dn});
		flash_op(16'hFFB3, 8'h5A, 1'b0, st);
		check("cmd_start", 32'h1, 32'(st));
		check("start_wr", {7'h0, 16'hFFB3, 8'h5A, 1'b0}, 32'(start_wr));
		axi_write(fsp_pkg::OFS_CONFIG, 32'h20, rs);
		check("read_invalid", 32'h1, 32'(read_invalid));
		key_entry(key ^ 64'h1, 1'b0);
		check("secure", 32'h1, 32'(secure));
		axi_read(fsp_pkg::OFS_OPTION, rd, rs);
		check("option", 32'h80, rd);
		key_entry(key, 1'b1);
		check("secure", 32'h1, 32'(secure));
		key_entry(key, 1'b0);
		check("secure", 32'h0, 32'(secure));
		axi_read(fsp_pkg::OFS_OPTION, rd, rs);
		check("option", 32'h82, rd);
		mem_op(1'b1, st, dn);
		check("mem_grant", 32'h2, {30'h0, st, dn});
		// Key unlock disabled: only a clean blank check unsecures
		do_reset(8'h00, 8'h01);
		axi_write(fsp_pkg::OFS_CONFIG, 32'h20, rs);
		key_entry(key, 1'b0);
		check("secure", 32'h1, 32'(secure));
		blank_ok <= 1'b1;
		@(posedge ref_clk);
		blank_ok <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check("secure", 32'h0, 32'(secure));
		// Boundary blocks on either side of the protected region
		for (int j = 0; j < 3; j++)
		begin
			bs = 7'({$random(seed)} % 127);
			do_reset(8'h80, {bs, 1'b0});
			cmd_op({bs + 7'h1, 9'h000}, st);
			check("cmd_go", 32'h0, 32'(st));
			cmd_op(16'hFFFF, st);
			check("cmd_go", 32'h0, 32'(st));
			axi_read(fsp_pkg::OFS_STATUS, rd, rs);
			check("violation", 32'h1, rd & 32'h1);
			cmd_op({bs, 9'h1FF}, st);
			check("cmd_go", 32'h1, 32'(st));
			check("go_addr", {16'h0, bs, 9'h1FF}, 32'(go_info.addr));
			axi_write(fsp_pkg::OFS_STATUS, 32'h1, rs);
			axi_read(fsp_pkg::OFS_STATUS, rd, rs);
			check("violation", 32'h0, rd & 32'h1);
			do_reset(8'h80, {bs, 1'b1});
			cmd_op(16'hFFFF, st);
			check("cmd_go", 32'h1, 32'(st));
		end
		print_verdict();
	end
endmodule
